/* shared/brk_regs.vh */
// Register map, field positions, reset values and vectors of the address breakpoint unit.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef BRK_REGS_VH
`define BRK_REGS_VH
// ============================================================
// Register offsets (byte addresses on the APB bus)
`define BRK_ADDR_HIGH_OFF 16'hFE0C
`define BRK_ADDR_LOW_OFF 16'hFE0D
`define BRK_STATUS_CONTROL_OFF 16'hFE0E
`define BRK_FLAG_CONTROL_OFF 16'hFE10
`define BRK_MODE_CONTROL_OFF 16'hFE14
// ============================================================
// Field positions
`define BRK_ENABLE_BIT 7
`define BRK_ACTIVE_BIT 6
`define BRK_CLEAR_FLAG_ENABLE_BIT 7
`define BRK_MONITOR_MODE_BIT 0
`define BRK_WDOG_DISABLE_BIT 1
`define BRK_IN_BREAK_BIT 7
// ============================================================
// Reset values
`define BRK_ADDR_RESET 8'h00
`define BRK_STATUS_CONTROL_RESET 8'h00
`define BRK_FLAG_CONTROL_RESET 8'h00
`define BRK_MODE_CONTROL_RESET 8'h02
// ============================================================
// Break vectors
`define BRK_VECTOR_NORMAL 16'hFFFC
`define BRK_VECTOR_MONITOR 16'hFEFC
`endif

/* rtl/brk_addr_compare.v */
// Sixteen-bit exact address comparator for the breakpoint unit.
// Assumes the address and the break address are synchronous to clk_sys.
`timescale 1ns/1ps
module brk_addr_compare #(
	parameter ADDR_W = 16
) (
	input wire clk_sys,
	input wire resetn,
	input wire [ADDR_W-1:0] cpu_addr,
	input wire cpu_addr_valid,
	input wire [ADDR_W-1:0] break_addr,
	input wire break_enable,
	output reg addr_match
);

// ============================================================
// Comparison
// exact enabled match
always @(posedge clk_sys)
begin
	if (!resetn)
		addr_match <= 1'b0;
	else
		addr_match <= break_enable && cpu_addr_valid && (cpu_addr == break_addr);
end

endmodule // brk_addr_compare

/* rtl/address_breakpoint_unit.v */
// Address breakpoint unit: break address registers, status/control, break sequencing.
// Assumes an APB master on clk_sys and a CPU that reports instruction boundaries.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "brk_regs.vh"
module address_breakpoint_unit #(
	parameter ADDR_W = 16
) (
	input wire clk_sys,
	input wire resetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [ADDR_W-1:0] cpu_pc,
	input wire cpu_pc_valid,
	input wire instr_boundary,
	input wire rti_executed,
	output reg breakpoint_signal,
	output reg swi_insert,
	output reg [ADDR_W-1:0] break_vector,
	output reg break_state,
	output reg flag_clear_allowed,
	output reg watchdog_hold
);

// Sequencer states.
localparam ST_IDLE = 2'b00;
localparam ST_PEND = 2'b01;
localparam ST_BREAK = 2'b10;

// Reset images of the control registers; each of their fields takes its bit from here.
localparam [7:0] SCR_RESET = `BRK_STATUS_CONTROL_RESET;
localparam [7:0] FLAG_RESET = `BRK_FLAG_CONTROL_RESET;
localparam [7:0] MODE_RESET = `BRK_MODE_CONTROL_RESET;

// Register fields and sequencer state.
reg [7:0] break_addr_high_reg;
reg [7:0] break_addr_low_reg;
reg break_enable_reg;
reg break_active_reg;
reg break_clear_flag_enable_reg;
reg monitor_mode_reg;
reg wdog_disable_reg;
reg [1:0] state_reg;
reg [1:0] state_next;
reg sw_break_req;

// Next values of every flip-flop except the sequencer state register.
reg [7:0] break_addr_high_next;
reg [7:0] break_addr_low_next;
reg break_enable_next;
reg break_active_next;
reg sw_break_req_next;
reg break_clear_flag_enable_next;
reg monitor_mode_next;
reg wdog_disable_next;
reg [31:0] prdata_next;
reg breakpoint_signal_next;
reg swi_insert_next;
reg [ADDR_W-1:0] break_vector_next;
reg break_state_next;
reg flag_clear_allowed_next;
reg watchdog_hold_next;

// Bus decode and comparator result.
wire addr_match;
wire wr_en;
wire rd_en;
wire hit_high;
wire hit_low;
wire hit_scr;
wire hit_flag;
wire hit_mode;
wire hit_any;

// ============================================================
// Address decode
function addr_is;
	input [31:0] a;
	input [15:0] off;
	begin
		addr_is = (a[31:16] == 16'h0000) && (a[15:0] == off);
	end
endfunction

assign hit_high = addr_is(paddr, `BRK_ADDR_HIGH_OFF);
assign hit_low = addr_is(paddr, `BRK_ADDR_LOW_OFF);
assign hit_scr = addr_is(paddr, `BRK_STATUS_CONTROL_OFF);
assign hit_flag = addr_is(paddr, `BRK_FLAG_CONTROL_OFF);
assign hit_mode = addr_is(paddr, `BRK_MODE_CONTROL_OFF);
assign hit_any = hit_high | hit_low | hit_scr | hit_flag | hit_mode;

// The slave answers in the first access cycle, so every transfer is two cycles.
assign pready = 1'b1;
assign pslverr = psel & penable & ~hit_any;
assign wr_en = psel & penable & pwrite & hit_any;
assign rd_en = psel & ~penable & ~pwrite;

// ============================================================
// Comparator
// program counter source
brk_addr_compare #(
	.ADDR_W(ADDR_W)
) u_compare (
	.clk_sys(clk_sys),
	.resetn(resetn),
	.cpu_addr(cpu_pc),
	.cpu_addr_valid(cpu_pc_valid),
	.break_addr({break_addr_high_reg, break_addr_low_reg}),
	.break_enable(break_enable_reg),
	.addr_match(addr_match)
);

// ============================================================
// Register next values
always @*
begin
	break_addr_high_next = break_addr_high_reg;
	break_addr_low_next = break_addr_low_reg;
	break_enable_next = break_enable_reg;
	break_active_next = break_active_reg;
	sw_break_req_next = 1'b0;
	break_clear_flag_enable_next = break_clear_flag_enable_reg;
	monitor_mode_next = monitor_mode_reg;
	wdog_disable_next = wdog_disable_reg;
	if (wr_en && hit_high)
		break_addr_high_next = pwdata[7:0];
	if (wr_en && hit_low)
		break_addr_low_next = pwdata[7:0];
	if (wr_en && hit_scr)
		break_enable_next = pwdata[`BRK_ENABLE_BIT];
	// set wins over clear
	// A match in the cycle of a clearing write keeps the flag, so no hit is lost.
	if (addr_match)
		break_active_next = 1'b1;
	else if (wr_en && hit_scr)
		break_active_next = pwdata[`BRK_ACTIVE_BIT];
	if (wr_en && hit_scr && pwdata[`BRK_ACTIVE_BIT])
		sw_break_req_next = 1'b1;
	if (wr_en && hit_flag)
		break_clear_flag_enable_next = pwdata[`BRK_CLEAR_FLAG_ENABLE_BIT];
	if (wr_en && hit_mode)
	begin
		monitor_mode_next = pwdata[`BRK_MONITOR_MODE_BIT];
		wdog_disable_next = pwdata[`BRK_WDOG_DISABLE_BIT];
	end
end

// ============================================================
// Register flip-flops
// clear high byte
always @(posedge clk_sys)
begin
	if (!resetn)
		break_addr_high_reg <= `BRK_ADDR_RESET;
	else
		break_addr_high_reg <= break_addr_high_next;
end

always @(posedge clk_sys)
begin
	if (!resetn)
		break_addr_low_reg <= `BRK_ADDR_RESET;
	else
		break_addr_low_reg <= break_addr_low_next;
end

always @(posedge clk_sys)
begin
	if (!resetn)
		break_enable_reg <= SCR_RESET[`BRK_ENABLE_BIT];
	else
		break_enable_reg <= break_enable_next;
end

always @(posedge clk_sys)
begin
	if (!resetn)
		break_active_reg <= SCR_RESET[`BRK_ACTIVE_BIT];
	else
		break_active_reg <= break_active_next;
end

always @(posedge clk_sys)
begin
	if (!resetn)
		sw_break_req <= 1'b0;
	else
		sw_break_req <= sw_break_req_next;
end

always @(posedge clk_sys)
begin
	if (!resetn)
		break_clear_flag_enable_reg <= FLAG_RESET[`BRK_CLEAR_FLAG_ENABLE_BIT];
	else
		break_clear_flag_enable_reg <= break_clear_flag_enable_next;
end

always @(posedge clk_sys)
begin
	if (!resetn)
		monitor_mode_reg <= MODE_RESET[`BRK_MONITOR_MODE_BIT];
	else
		monitor_mode_reg <= monitor_mode_next;
end

always @(posedge clk_sys)
begin
	if (!resetn)
		wdog_disable_reg <= MODE_RESET[`BRK_WDOG_DISABLE_BIT];
	else
		wdog_disable_reg <= wdog_disable_next;
end

// ============================================================
// Read data
// The word is captured in the setup cycle and stands through the access cycle.
always @*
begin
	prdata_next = prdata;
	if (rd_en)
	begin
		if (hit_high)
			prdata_next = {24'h000000, break_addr_high_reg};
		else if (hit_low)
			prdata_next = {24'h000000, break_addr_low_reg};
		else if (hit_scr)
			prdata_next = {24'h000000, break_enable_reg, break_active_reg, 6'h00};
		else if (hit_flag)
			prdata_next = {24'h000000, break_clear_flag_enable_reg, 7'h00};
		else if (hit_mode)
			prdata_next = {24'h000000, (state_reg == ST_BREAK), 5'h00,
				wdog_disable_reg, monitor_mode_reg};
		else
			prdata_next = 32'h00000000;
	end
end

always @(posedge clk_sys)
begin
	if (!resetn)
		prdata <= 32'h00000000;
	else
		prdata <= prdata_next;
end

// ============================================================
// Break sequencer
always @*
begin
	state_next = state_reg;
	case (state_reg)
		ST_IDLE:
		begin
			if (addr_match || sw_break_req)
				state_next = ST_PEND;
		end
		ST_PEND:
		begin
			if (instr_boundary)
				state_next = ST_BREAK;
		end
		ST_BREAK:
		begin
			if (rti_executed)
				state_next = ST_IDLE;
		end
		default:
			state_next = ST_IDLE;
	endcase
end

// ============================================================
// Break outputs
always @*
begin
	breakpoint_signal_next = (state_next == ST_PEND);
	swi_insert_next = (state_reg == ST_PEND) && (state_next == ST_BREAK);
	break_vector_next = monitor_mode_reg ? `BRK_VECTOR_MONITOR : `BRK_VECTOR_NORMAL;
	break_state_next = (state_next == ST_BREAK);
	flag_clear_allowed_next = (state_next != ST_BREAK) || break_clear_flag_enable_reg;
	watchdog_hold_next = (state_next == ST_BREAK) && wdog_disable_reg;
end

always @(posedge clk_sys)
begin
	if (!resetn)
	begin
		state_reg <= ST_IDLE;
		breakpoint_signal <= 1'b0;
		swi_insert <= 1'b0;
		break_vector <= `BRK_VECTOR_NORMAL;
		break_state <= 1'b0;
		flag_clear_allowed <= 1'b0;
		watchdog_hold <= 1'b0;
	end
	else
	begin
		state_reg <= state_next;
		breakpoint_signal <= breakpoint_signal_next;
		swi_insert <= swi_insert_next;
		break_vector <= break_vector_next;
		break_state <= break_state_next;
		flag_clear_allowed <= flag_clear_allowed_next;
		watchdog_hold <= watchdog_hold_next;
	end
end

endmodule // address_breakpoint_unit

/* test/brk_checker.sv */
// Checker: assertions on the ports of the breakpoint unit.
// Assumes the bind below and a synchronous active-low reset.
`timescale 1ns/1ps
module brk_checker #(parameter ADDR_W = 16) (
	input wire clk_sys,
	input wire resetn,
	input wire psel,
	input wire penable,
	input wire pready,
	input wire pslverr,
	input wire instr_boundary,
	input wire rti_executed,
	input wire breakpoint_signal,
	input wire swi_insert,
	input wire [ADDR_W-1:0] break_vector,
	input wire break_state,
	input wire flag_clear_allowed,
	input wire watchdog_hold
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	no_wait_a: assert property (pready) else $error("pready low");
	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("stray pslverr");
	break_start_a: assert property (
		breakpoint_signal && instr_boundary && !break_state |=> swi_insert && break_state)
		else $error("break not begun");
	at_boundary_a: assert property (
		swi_insert |-> $past(breakpoint_signal) && $past(instr_boundary)) else $error("off boundary");
	swi_pulse_a: assert property (swi_insert |=> !swi_insert) else $error("swi too long");
	rti_end_a: assert property (break_state && rti_executed |=> !break_state)
		else $error("break not ended");
	break_vector_a: assert property (
		break_vector == 16'hFFFC || break_vector == 16'hFEFC)
		else $error("bad vector");
	state_rise_a: assert property ($rose(break_state) |-> swi_insert) else $error("no swi");
	pend_hold_a: assert property (
		breakpoint_signal && !instr_boundary |=> breakpoint_signal)
		else $error("pending break dropped");
	wdog_scope_a: assert property (watchdog_hold |-> break_state)
		else $error("hold outside break");
	flag_open_a: assert property (
		$past(resetn) && !break_state |-> flag_clear_allowed)
		else $error("flag clear blocked");
endmodule // brk_checker
bind address_breakpoint_unit brk_checker #(.ADDR_W(ADDR_W)) chk_u (.*);

/* test/cpu_model.sv */
// Model of the CPU core: steps the program counter, marks instruction ends.
// Assumes swi_insert and break_vector come from the breakpoint unit.
`timescale 1ns/1ps
module cpu_model #(parameter ILEN = 4) (
	input wire clk_sys,
	input wire resetn,
	input wire swi_insert,
	input wire [15:0] break_vector,
	input wire do_rti,
	output reg [15:0] cpu_pc,
	output wire cpu_pc_valid,
	output wire instr_boundary,
	output reg rti_executed
);
	reg [31:0] cnt_reg;
	assign cpu_pc_valid = resetn;
	assign instr_boundary = resetn && cnt_reg == ILEN - 1;
	always @(posedge clk_sys)
	begin
		cnt_reg <= (!resetn || instr_boundary) ? 32'h0 : cnt_reg + 32'h1;
		rti_executed <= resetn && do_rti;
		if (!resetn)
			cpu_pc <= 16'h0100;
		else if (swi_insert)
			cpu_pc <= break_vector;
		else if (instr_boundary)
			cpu_pc <= cpu_pc + 16'h0001;
	end
endmodule // cpu_model

/* test/tb_address_breakpoint_unit.sv */
// Testbench: APB register access and break sequencing of the breakpoint unit.
// Assumes a zero-wait APB slave and the CPU model on the far side.
`timescale 1ns/1ps
module tb_address_breakpoint_unit;
	reg clk_sys = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, do_rti = 1'b0;
	reg [31:0] paddr = 32'h0, pwdata = 32'h0;
	reg serr, got;
	integer mismatches = 0, cmp_count = 0;
	wire [31:0] prdata;
	wire [15:0] cpu_pc, break_vector;
	wire pready, pslverr, cpu_pc_valid, instr_boundary, rti_executed, breakpoint_signal;
	wire swi_insert, break_state, flag_clear_allowed, watchdog_hold;
	always #4 clk_sys = ~clk_sys;
	address_breakpoint_unit dut_u (.*);
	cpu_model cpu_u (.*);
	task end_of_test;
	begin
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask
	task chk(input [63:0] nm, input [31:0] e, input [31:0] s);
	begin
		cmp_count = cmp_count + 1;
		if (s !== e)
		begin
			mismatches = mismatches + 1;
			$display("MISMATCH %0s exp %h got %h", nm, e, s);
		end
	end
	endtask
	// Waits a bounded number of edges for pready (which 0) or swi_insert (which 1).
	task wait_hi(input integer lim, input integer which);
		integer i;
	begin
		got = 1'b0;
		for (i = 0; i < lim && !got; i = i + 1)
		begin
			@(posedge clk_sys);
			got = (which ? swi_insert : pready) === 1'b1;
		end
	end
	endtask
	task xfer(input w, input [15:0] a, input [7:0] d);
	begin
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {16'h0, a};
		pwdata <= {24'h0, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		wait_hi(50, 0);
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", 1'h1, got);
		if (!got)
			end_of_test;
		if (!w)
			chk("rdata", d, prdata);
	end
	endtask
	initial
	begin
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		xfer(0, 16'hFE0C, 8'h00);
		xfer(0, 16'hFE0E, 8'h00);
		xfer(1, 16'hFE0D, 8'h20);
		xfer(1, 16'hFE0C, 8'h81);
		xfer(1, 16'hFE0E, 8'h80);
		xfer(0, 16'hFE0C, 8'h81);
		// The program counter passes 0120 here: low byte matches, high byte does not.
		wait_hi(150, 1);
		chk("partial", 1'h0, got);
		xfer(1, 16'hFE0C, 8'h01);
		xfer(1, 16'hFE0D, 8'h40);
		wait_hi(400, 1);
		chk("matchbrk", 1'h1, got);
		if (!got)
			end_of_test;
		xfer(0, 16'hFE0E, 8'hC0);
		chk("vector", 16'hFFFC, break_vector);
		chk("flagclr", 1'h0, flag_clear_allowed);
		chk("wdog", 1'h1, watchdog_hold);
		xfer(1, 16'hFE0E, 8'h80);
		xfer(0, 16'hFE0E, 8'h80);
		do_rti <= 1'b1;
		@(posedge clk_sys);
		do_rti <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk("state", 1'h0, break_state);
		xfer(1, 16'hFE10, 8'h80);
		xfer(1, 16'hFE14, 8'h01);
		xfer(1, 16'hFE0E, 8'hFF);
		wait_hi(20, 1);
		chk("swbrk", 1'h1, got);
		if (!got)
			end_of_test;
		xfer(0, 16'hFE0E, 8'hC0);
		chk("vector", 16'hFEFC, break_vector);
		chk("flagclr", 1'h1, flag_clear_allowed);
		chk("wdog", 1'h0, watchdog_hold);
		xfer(0, 16'hFE0F, 8'h00);
		chk("slverr", 1'h1, serr);
		end_of_test;
	end
endmodule // tb_address_breakpoint_unit
